// ==== hdl/vmtr_regs.sv ====
// Mode and timing control registers of the video encoder, with bus slave
`timescale 1ns/1ps
`include "vmtr_defines.svh"

module vmtr_regs #(
    parameter logic [1:0] REVISION  = 2'h1, // Arbitrary revision code
    parameter logic [6:0] DEV_ADDR  = 7'h2A, // Arbitrary bus address
    parameter int         DLY_DEPTH = 64
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_scl,
    input  wire logic                  i_sda,
    output logic                       o_sda_out,
    output logic                       o_sda_oe,
    input  wire logic                  i_pal_mode,
    input  wire logic                  i_ttx_pin,
    input  wire logic                  i_ttx_bit_slot,
    input  wire logic [15:0]           i_pixel,
    output logic [15:0]                o_pixel,
    output logic                       o_force_black,
    output logic [9:0]                 o_active_pixels,
    output logic                       o_chroma_on,
    output logic                       o_burst_on,
    output logic [6:0]                 o_dac_drive_pct,
    output logic                       o_vbi_pass,
    output vmtr_pkg::vmtr_dac_src_t    o_dac_a_src,
    output vmtr_pkg::vmtr_dac_src_t    o_dac_b_src,
    output vmtr_pkg::vmtr_dac_src_t    o_dac_c_src,
    output vmtr_pkg::vmtr_dac_src_t    o_dac_d_src,
    output logic [3:0]                 o_dac_on,
    output logic                       o_ttx_bit,
    output logic                       o_ttx_request,
    output logic                       o_pedestal_on,
    output logic                       o_sleep,
    output logic                       o_master,
    output logic [1:0]                 o_timing_mode,
    output logic                       o_blank_honoured,
    output logic                       o_timing_counter_reset,
    output logic [2:0]                 o_vsync_half_lines,
    output logic [1:0]                 o_hsync_width,
    output logic [1:0]                 o_hsync_vsync_offset,
    output logic [1:0]                 o_field_edge_offset,
    output logic [1:0]                 o_vsync_width,
    output logic [1:0]                 o_hsync_pixel_adjust
);
    import vmtr_pkg::*;

    localparam int AW = $clog2(DLY_DEPTH);
    // Least time, so the step rounds up to whole clocks
    localparam int STEP_CYC = (`VMTR_LUMA_STEP_NS * 1000 + `VMTR_CLK_PERIOD_PS - 1)
                              / `VMTR_CLK_PERIOD_PS;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [2:0] pin_s1, pin_s2, pin_s3, pin_ok;

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pin_s1 <= 3'h6;
            pin_s2 <= 3'h6;
            pin_s3 <= 3'h6;
            pin_ok <= 3'h6;
        end else begin
            pin_s1 <= {i_scl, i_sda, i_ttx_pin};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_ok <= (pin_s2 & pin_s3) | (pin_ok & (pin_s2 ^ pin_s3));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial register port

    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] sub;
    logic [7:0] rdata;

    vmtr_i2c #(
        .DEV_ADDR (DEV_ADDR)
    ) u_i2c (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_scl     (pin_ok[2]),
        .i_sda     (pin_ok[1]),
        .i_rdata   (rdata),
        .o_sda_out (o_sda_out),
        .o_sda_oe  (o_sda_oe),
        .o_wr_en   (wr_en),
        .o_wr_addr (wr_addr),
        .o_wr_data (wr_data),
        .o_sub     (sub)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [7:0] mode1, mode2, mode4, time0, time1;
    logic [7:2] mode3_hi;

    // Address decode for writes
    wire wr_m1 = wr_en && wr_addr == `VMTR_OFS_MODE1;
    wire wr_m2 = wr_en && wr_addr == `VMTR_OFS_MODE2;
    wire wr_m3 = wr_en && wr_addr == `VMTR_OFS_MODE3;
    wire wr_m4 = wr_en && wr_addr == `VMTR_OFS_MODE4;
    wire wr_t0 = wr_en && wr_addr == `VMTR_OFS_TIME0;
    wire wr_t1 = wr_en && wr_addr == `VMTR_OFS_TIME1;

    // Reset also clears sleep, so reset always wakes the part
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            mode1    <= `VMTR_RST_MODE1;
            mode2    <= `VMTR_RST_MODE2;
            mode3_hi <= 6'(`VMTR_RST_MODE3 >> 2);
            mode4    <= `VMTR_RST_MODE4;
            time0    <= `VMTR_RST_TIME0;
            time1    <= `VMTR_RST_TIME1;
        end else begin
            if (wr_m1) mode1 <= wr_data;
            if (wr_m2) mode2 <= wr_data;
            if (wr_m3) mode3_hi <= wr_data[7:2];
            if (wr_m4) mode4 <= wr_data;
            if (wr_t0) time0 <= wr_data;
            if (wr_t1) time1 <= wr_data;
        end
    end

    // Read mux; unmapped subaddresses read as zero
    assign rdata = (sub == `VMTR_OFS_MODE1) ? mode1 :
                   (sub == `VMTR_OFS_MODE2) ? mode2 :
                   (sub == `VMTR_OFS_MODE3) ? {mode3_hi, REVISION} :
                   (sub == `VMTR_OFS_MODE4) ? mode4 :
                   (sub == `VMTR_OFS_TIME0) ? time0 :
                   (sub == `VMTR_OFS_TIME1) ? time1 : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Field extraction

    wire       line_sel  = mode2[`VMTR_B_LINE];
    wire       chroma_en = mode2[`VMTR_B_CHROMA];
    wire       burst_en  = mode2[`VMTR_B_BURST];
    wire       low_power = mode2[`VMTR_B_LOWPWR];
    wire       vbi_open  = mode3_hi[`VMTR_B_VBI];
    wire       euro_out  = mode3_hi[`VMTR_B_EURO];
    wire       chroma_sel = mode3_hi[`VMTR_B_CSEL];
    wire       ttx_en    = mode3_hi[`VMTR_B_TTXEN];
    wire       req_mode  = mode3_hi[`VMTR_B_REQM];
    wire       def_col   = mode3_hi[`VMTR_B_DEFC];
    wire       out_sel   = mode4[`VMTR_B_OSEL];
    wire       yuv_sel   = mode4[`VMTR_B_YUV];
    wire       vs3       = mode4[`VMTR_B_VS3];
    wire       ped_en    = mode4[`VMTR_B_PED];
    wire       sleep     = mode4[`VMTR_B_SLEEP];
    wire       master    = time0[`VMTR_B_MS];
    wire [1:0] tmode     = time0[`VMTR_B_TMODE +: 2];
    wire       blk_ctrl  = time0[`VMTR_B_BLK];
    wire [1:0] ldly      = time0[`VMTR_B_LDLY +: 2];
    wire       width8    = ~time0[`VMTR_B_PWIDTH];
    wire       trst      = time0[`VMTR_B_TRST];

    ////////////////////////////////////////////////////////////////////////////
    // DAC source map

    // The comp slot lands on A or D in every mode; chroma select puts C there in place of composite
    function automatic vmtr_dac_map_t dac_map(input logic osel, input logic yuv,
                                             input logic csel, input logic euro);
        vmtr_dac_src_t comp, slot_b, slot_c, slot_y;
        vmtr_dac_map_t m;
        comp   = csel ? SRC_C : SRC_CVBS;
        slot_b = !osel ? SRC_CVBS : (yuv ? SRC_U : SRC_B);
        slot_c = !osel ? SRC_C : (yuv ? SRC_V : SRC_R);
        slot_y = (!osel || yuv) ? SRC_Y : SRC_G;
        m.a = euro ? slot_y : comp;
        m.b = slot_b;
        m.c = slot_c;
        m.d = euro ? comp : slot_y;
        return m;
    endfunction

    wire vmtr_dac_map_t next_map = dac_map(out_sel, yuv_sel, chroma_sel, euro_out);

    // Power bit set or sleep turns a DAC off; order is D, C, B, A
    wire [3:0] next_dac_on = ~{mode1[`VMTR_B_DAC_D], mode1[`VMTR_B_DAC_C],
                               mode1[`VMTR_B_DAC_B], mode1[`VMTR_B_DAC_A]}
                             & {4{~sleep}};

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode

    wire [9:0] next_active = !line_sel ? `VMTR_PIX_FULL :
                             (i_pal_mode ? `VMTR_PIX_PAL : `VMTR_PIX_NTSC);

    wire [6:0] next_drive = sleep ? 7'h00 :
                            low_power ? (`VMTR_DRIVE_FULL_PCT - `VMTR_LOWPWR_CUT_PCT)
                                      : `VMTR_DRIVE_FULL_PCT;

    // Blank control wins, and slave mode 0 cannot pass VBI
    wire slave_m0 = !master && tmode == 2'h0;
    wire next_vbi = vbi_open && !slave_m0 && !blk_ctrl;

    wire next_ttx_bit = ttx_en & pin_ok[0];
    wire next_ttx_req = ttx_en & (req_mode ? i_ttx_bit_slot : 1'b1);

    wire next_ped = ped_en & ~i_pal_mode;

    wire [2:0] next_vs_half = !vs3 ? 3'h0 :
                              (i_pal_mode ? `VMTR_VS_HALF_PAL : `VMTR_VS_HALF_NTSC);

    // Field is shared; only the selected mode sees it
    wire [1:0] fev = time1[`VMTR_B_FEV +: 2];
    wire [1:0] next_edge_ofs = (tmode == 2'h1) ? fev : 2'h0;
    wire [1:0] next_vs_width = (tmode == 2'h2) ? fev : 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Timing counter reset toggle

    logic trst_high;

    // Pulse only after a full low-high-low pass
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            trst_high <= 1'b0;
            o_timing_counter_reset <= 1'b0;
        end else begin
            trst_high <= trst ? 1'b1 : 1'b0;
            o_timing_counter_reset <= trst_high & ~trst;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pixel path with luma delay

    logic [15:0]   pix_in;
    logic [15:0]   dly_mem [DLY_DEPTH];
    logic [AW-1:0] wp;

    // Narrow port uses only the low eight pins
    wire [15:0] next_pix = width8 ? {8'h00, i_pixel[7:0]} : i_pixel;

    wire [AW-1:0] dly_cyc = AW'(int'(ldly) * STEP_CYC);
    wire [AW-1:0] rp = wp - dly_cyc;
    wire [15:0] pix_dly = (dly_cyc == '0) ? pix_in : dly_mem[rp];

    // Memory holds no reset; its content is never read before written
    always_ff @(posedge i_clk) begin
        dly_mem[wp] <= pix_in;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pix_in        <= 16'h0000;
            wp            <= '0;
            o_pixel       <= 16'h0000;
            o_force_black <= 1'b0;
        end else begin
            pix_in        <= next_pix;
            wp            <= wp + 1'b1;
            o_pixel       <= pix_dly;
            o_force_black <= def_col && pix_dly == 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered control outputs

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_active_pixels <= `VMTR_PIX_FULL;
            {o_chroma_on, o_burst_on, o_vbi_pass} <= 3'h0;
            o_dac_drive_pct <= `VMTR_DRIVE_FULL_PCT;
            o_dac_a_src <= SRC_CVBS;
            o_dac_b_src <= SRC_CVBS;
            o_dac_c_src <= SRC_C;
            o_dac_d_src <= SRC_Y;
            o_dac_on <= 4'h0;
            {o_ttx_bit, o_ttx_request, o_pedestal_on, o_sleep} <= 4'h0;
            {o_master, o_timing_mode, o_blank_honoured} <= 4'h0;
            o_vsync_half_lines <= 3'h0;
            {o_hsync_width, o_hsync_vsync_offset} <= 4'h0;
            {o_field_edge_offset, o_vsync_width, o_hsync_pixel_adjust} <= 6'h00;
        end else begin
            o_active_pixels <= next_active;
            o_chroma_on <= chroma_en;
            o_burst_on <= burst_en;
            o_dac_drive_pct <= next_drive;
            o_vbi_pass <= next_vbi;
            o_dac_a_src <= next_map.a;
            o_dac_b_src <= next_map.b;
            o_dac_c_src <= next_map.c;
            o_dac_d_src <= next_map.d;
            o_dac_on <= next_dac_on;
            o_ttx_bit <= next_ttx_bit;
            o_ttx_request <= next_ttx_req;
            o_pedestal_on <= next_ped;
            o_sleep <= sleep;
            o_master <= master;
            o_timing_mode <= tmode;
            o_blank_honoured <= ~master & blk_ctrl;
            o_vsync_half_lines <= next_vs_half;
            o_hsync_width <= time1[`VMTR_B_HSW +: 2];
            o_hsync_vsync_offset <= time1[`VMTR_B_HVO +: 2];
            o_field_edge_offset <= next_edge_ofs;
            o_vsync_width <= next_vs_width;
            o_hsync_pixel_adjust <= time1[`VMTR_B_HPA +: 2];
        end
    end

endmodule

// ==== hdl/vmtr_defines.svh ====
// Register offsets, field positions, reset values and timing figures
`ifndef VMTR_DEFINES_SVH
`define VMTR_DEFINES_SVH
`define VMTR_OFS_MODE1 8'h01
`define VMTR_OFS_MODE2 8'h02
`define VMTR_OFS_MODE3 8'h03
`define VMTR_OFS_MODE4 8'h04
`define VMTR_OFS_TIME0 8'h07
`define VMTR_OFS_TIME1 8'h08
`define VMTR_RST_MODE1 8'h58
`define VMTR_RST_MODE2 8'h00
`define VMTR_RST_MODE3 8'h00
`define VMTR_RST_MODE4 8'h10
`define VMTR_RST_TIME0 8'h00
`define VMTR_RST_TIME1 8'h00
`define VMTR_B_DAC_C 3
`define VMTR_B_DAC_D 4
`define VMTR_B_DAC_B 5
`define VMTR_B_DAC_A 6
`define VMTR_B_LINE 3
`define VMTR_B_CHROMA 4
`define VMTR_B_BURST 5
`define VMTR_B_LOWPWR 6
`define VMTR_B_VBI 2
`define VMTR_B_EURO 3
`define VMTR_B_CSEL 4
`define VMTR_B_TTXEN 5
`define VMTR_B_REQM 6
`define VMTR_B_DEFC 7
`define VMTR_B_OSEL 0
`define VMTR_B_YUV 1
`define VMTR_B_VS3 3
`define VMTR_B_PED 4
`define VMTR_B_SLEEP 6
`define VMTR_B_MS 0
`define VMTR_B_TMODE 1
`define VMTR_B_BLK 3
`define VMTR_B_LDLY 4
`define VMTR_B_PWIDTH 6
`define VMTR_B_TRST 7
`define VMTR_B_HSW 0
`define VMTR_B_HVO 2
`define VMTR_B_FEV 4
`define VMTR_B_HPA 6
`define VMTR_PIX_FULL 10'h2D0
`define VMTR_PIX_NTSC 10'h2C6
`define VMTR_PIX_PAL 10'h2BE
`define VMTR_DRIVE_FULL_PCT 7'h64
`define VMTR_LOWPWR_CUT_PCT 7'h2D
`define VMTR_VS_HALF_NTSC 3'h6
`define VMTR_VS_HALF_PAL 3'h5
`define VMTR_LUMA_STEP_NS 74
`define VMTR_CLK_PERIOD_PS 5000
`endif

// ==== hdl/vmtr_pkg.sv ====
// Types shared by the encoder mode and timing register block
package vmtr_pkg;
    typedef enum logic [2:0] {
        SRC_CVBS, SRC_Y, SRC_C, SRC_U, SRC_V, SRC_R, SRC_G, SRC_B
    } vmtr_dac_src_t;
    typedef struct packed {
        vmtr_dac_src_t a;
        vmtr_dac_src_t b;
        vmtr_dac_src_t c;
        vmtr_dac_src_t d;
    } vmtr_dac_map_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_DEV, ST_SUB, ST_WRITE, ST_READ
    } vmtr_i2c_state_t;
endpackage

// ==== hdl/vmtr_i2c.sv ====
// Two-wire serial slave with subaddress pointer and auto increment
`timescale 1ns/1ps
module vmtr_i2c #(
    parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary bus address
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic [7:0] i_rdata,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    output logic            o_wr_en,
    output logic [7:0]      o_wr_addr,
    output logic [7:0]      o_wr_data,
    output logic [7:0]      o_sub
);
    import vmtr_pkg::*;
    vmtr_i2c_state_t state;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic       scl_q, sda_q, ack, rw, mack;
    wire start = scl_q & i_scl & sda_q & ~i_sda;
    wire stop  = scl_q & i_scl & ~sda_q & i_sda;
    wire rise  = ~scl_q & i_scl;
    wire fall  = scl_q & ~i_scl;

    // Bit engine; data moves on SCL falling edges, samples on rising
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
            {sh, cnt, ack, rw, mack} <= '0;
            {scl_q, sda_q} <= 2'h3;
            {o_sda_out, o_sda_oe, o_wr_en} <= 3'h0;
            {o_wr_addr, o_wr_data, o_sub} <= '0;
        end else begin
            scl_q <= i_scl;
            sda_q <= i_sda;
            o_wr_en <= 1'b0;
            o_sda_out <= 1'b0;
            if (start) begin
                state <= ST_DEV;
                {cnt, ack, o_sda_oe} <= '0;
            end else if (stop) begin
                state <= ST_IDLE;
                {ack, o_sda_oe} <= '0;
            end else if (rise && state == ST_READ) begin
                if (cnt == 4'h8) mack <= ~i_sda;
                cnt <= cnt + 4'h1;
            end else if (rise && !ack && state != ST_IDLE) begin
                sh <= {sh[6:0], i_sda};
                cnt <= cnt + 4'h1;
            end else if (fall && state == ST_READ) begin
                if (cnt == 4'h9) begin
                    cnt <= 4'h0;
                    if (mack) begin
                        sh <= i_rdata;
                        o_sub <= o_sub + 8'h01;
                        o_sda_oe <= ~i_rdata[7];
                    end else begin
                        state <= ST_IDLE;
                        o_sda_oe <= 1'b0;
                    end
                end else if (cnt == 4'h8) begin
                    o_sda_oe <= 1'b0; // Master owns its ack slot
                end else begin
                    sh <= {sh[6:0], 1'b0};
                    o_sda_oe <= ~sh[6];
                end
            end else if (fall && ack) begin
                {ack, o_sda_oe, cnt} <= '0;
                if (state == ST_DEV && rw) begin
                    state <= ST_READ;
                    sh <= i_rdata;
                    o_sub <= o_sub + 8'h01;
                    o_sda_oe <= ~i_rdata[7];
                end else if (state != ST_WRITE) begin
                    state <= (state == ST_DEV) ? ST_SUB : ST_WRITE;
                end
            end else if (fall && cnt == 4'h8) begin
                case (state)
                    ST_DEV: begin
                        if (sh[7:1] == DEV_ADDR) begin
                            {ack, o_sda_oe} <= 2'h3;
                            rw <= sh[0];
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                    ST_SUB: begin
                        o_sub <= sh;
                        {ack, o_sda_oe} <= 2'h3;
                    end
                    ST_WRITE: begin
                        o_wr_en <= 1'b1;
                        o_wr_addr <= o_sub;
                        o_wr_data <= sh;
                        o_sub <= o_sub + 8'h01;
                        {ack, o_sda_oe} <= 2'h3;
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// ==== tb/vmtr_regs_assertions.sv ====
// Port checker for the encoder mode and timing register block
`timescale 1ns/1ps
module vmtr_chk (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_pal_mode,
    input wire logic [15:0] o_pixel,
    input wire logic        o_force_black,
    input wire logic [9:0]  o_active_pixels,
    input wire logic [6:0]  o_dac_drive_pct,
    input wire logic        o_vbi_pass,
    input wire logic [3:0]  o_dac_on,
    input wire logic        o_pedestal_on,
    input wire logic        o_sleep,
    input wire logic        o_master,
    input wire logic [1:0]  o_timing_mode,
    input wire logic        o_blank_honoured,
    input wire logic        o_timing_counter_reset,
    input wire logic [2:0]  o_vsync_half_lines
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////
    // Outputs follow the standard sampled one clock before
    a_line_length: assert property (
        o_active_pixels != 10'h2D0 |-> o_active_pixels == ($past(i_pal_mode) ? 10'h2BE : 10'h2C6))
        else $error("active line length wrong");
    a_drive_levels: assert property (
        o_dac_drive_pct inside {7'h64, 7'h37, 7'h00}) else $error("drive level wrong");
    a_sleep_dark: assert property (
        o_sleep |-> o_dac_on == 4'h0 && o_dac_drive_pct == 7'h00) else $error("sleep not dark");
    a_pal_no_pedestal: assert property (
        $past(i_pal_mode) |-> !o_pedestal_on) else $error("pedestal in PAL");
    a_vbi_slave_zero: assert property (
        !o_master && o_timing_mode == 2'h0 |-> !o_vbi_pass) else $error("vbi in slave 0");
    a_blank_wins: assert property (
        o_blank_honoured |-> !o_vbi_pass && !o_master) else $error("blank not winning");
    a_trst_single: assert property (
        o_timing_counter_reset |=> !o_timing_counter_reset) else $error("long counter reset");
    a_vsync_len: assert property (
        o_vsync_half_lines != 3'h0 |-> o_vsync_half_lines == ($past(i_pal_mode) ? 3'h5 : 3'h6))
        else $error("vsync length wrong");
    a_black_zero: assert property (
        o_force_black |-> o_pixel == 16'h0000) else $error("black on nonzero pixel");
    // Main scenarios reached
    c_sleep: cover property (o_sleep);
    c_trst: cover property (o_timing_counter_reset);
    c_vbi: cover property (o_vbi_pass);
    c_black: cover property (o_force_black);
endmodule

bind vmtr_regs vmtr_chk chk_u (.*);

// ==== tb/tb.sv ====
// Self-checking bench for the encoder mode and timing register block
`timescale 1ns/1ps
module tb;
    import vmtr_pkg::*;
    logic          i_clk, i_rst_n, i_scl, sda_drv, i_pal_mode, i_ttx_pin, i_ttx_bit_slot;
    logic          o_sda_out, o_sda_oe, o_force_black, o_chroma_on, o_burst_on, o_vbi_pass;
    logic          o_ttx_bit, o_ttx_request, o_pedestal_on, o_sleep, o_master;
    logic          o_blank_honoured, o_timing_counter_reset;
    logic [15:0]   i_pixel, o_pixel;
    logic [9:0]    o_active_pixels;
    logic [6:0]    o_dac_drive_pct;
    logic [3:0]    o_dac_on;
    logic [2:0]    o_vsync_half_lines;
    logic [1:0]    o_timing_mode, o_hsync_width, o_hsync_vsync_offset;
    logic [1:0]    o_field_edge_offset, o_vsync_width, o_hsync_pixel_adjust;
    vmtr_dac_src_t o_dac_a_src, o_dac_b_src, o_dac_c_src, o_dac_d_src;
    logic [31:0]   seed;
    logic [31:0]   bg = 32'hD8139ACE;
    logic [7:0]    rd;
    logic [15:0]   pq [$];
    int            num_errors, check_count, pulses, mr [0:8];
    // Open-drain data line with pull-up
    wire           sda = o_sda_oe ? 1'b0 : sda_drv;

    vmtr_regs dut_u (.i_sda(sda), .*);

    ////////////////////////////////////////////////////////////////
    // 200 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
    endfunction

    // Background pixel and teletext traffic, zero pixels often
    always @(negedge i_clk) begin
        bg <= lfsr(bg);
        i_pixel <= (bg[3:0] == 4'h0) ? 16'h0000 : bg[15:0];
        i_ttx_pin <= bg[20];
        i_ttx_bit_slot <= bg[21];
    end

    // Counter reset pulses seen
    always @(posedge i_clk) if (o_timing_counter_reset) pulses++;

    // Pixel history, newest first, as sampled at each edge
    always @(posedge i_clk) begin
        pq.push_front(i_pixel);
        if (pq.size() > 64) void'(pq.pop_back());
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic mreset();
        mr = '{default: 0};
        mr[1] = 'h58;
        mr[3] = 1;
        mr[4] = 'h10;
    endtask

    ////////////////////////////////////////////////////////////////
    // Two-wire master, SCL half period of 8 clocks
    task automatic hc();
        repeat (8) @(negedge i_clk);
    endtask
    task automatic sbit(input logic b);
        sda_drv = b;
        hc();
        i_scl = 1'b1;
        hc();
        i_scl = 1'b0;
    endtask
    task automatic start();
        sda_drv = 1'b1;
        hc();
        i_scl = 1'b1;
        hc();
        sda_drv = 1'b0;
        hc();
        i_scl = 1'b0;
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        hc();
        i_scl = 1'b1;
        hc();
        sda_drv = 1'b1;
        hc();
    endtask
    task automatic sbyte(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) sbit(d[i]);
        sda_drv = 1'b1;
        hc();
        i_scl = 1'b1;
        hc();
        chk(16'(sda), 16'h0000);
        i_scl = 1'b0;
    endtask
    // Burst write with auto increment; holes drop their bytes
    task automatic wr(input int a, input int n, input logic [31:0] d);
        start();
        sbyte(8'h54);
        sbyte(8'(a));
        for (int k = 0; k < n; k++) begin
            sbyte(d[31-8*k -: 8]);
            if ((a + k) inside {1, 2, 4, 7, 8}) mr[a+k] = int'(d[31-8*k -: 8]);
            if (a + k == 3) mr[3] = int'({d[31-8*k -: 6], 2'h1});
        end
        stop();
        repeat (8) @(negedge i_clk);
    endtask
    task automatic rdchk(input int a, input int n = 1);
        start();
        sbyte(8'h54);
        sbyte(8'(a));
        start();
        sbyte(8'h55);
        for (int k = 0; k < n; k++) begin
            sda_drv = 1'b1;
            for (int i = 7; i >= 0; i--) begin
                hc();
                i_scl = 1'b1;
                hc();
                rd[i] = sda;
                i_scl = 1'b0;
            end
            sbit(k == n - 1); // Master ack continues, nack ends
            chk(16'(rd), 16'(mr[a + k]));
        end
        stop();
    endtask

    // Control outputs against the register model, except the counter reset and o_ttx_bit while teletext is on
    task automatic chk_outs();
        int m1, m2, m3, m4, t0, t1, p;
        logic [2:0] b, c, g, cp;
        logic [15:0] px;
        m1 = mr[1];
        m2 = mr[2];
        m3 = mr[3];
        m4 = mr[4];
        t0 = mr[7];
        t1 = mr[8];
        p = int'(i_pal_mode);
        chk(o_active_pixels, m2[3] ? (p[0] ? 10'h2BE : 10'h2C6) : 10'h2D0);
        chk({o_chroma_on, o_burst_on}, {m2[4], m2[5]});
        chk(o_dac_drive_pct, m4[6] ? 7'h00 : (m2[6] ? 7'h37 : 7'h64));
        chk(o_dac_on, m4[6] ? 4'h0 : 4'(~{m1[4], m1[3], m1[5], m1[6]}));
        chk(o_vbi_pass, m3[2] & !(!t0[0] & t0[2:1] == 0) & !t0[3]);
        if (m4[0]) {b, c, g} = m4[1] ? {SRC_U, SRC_V, SRC_Y} : {SRC_B, SRC_R, SRC_G};
        else {b, c, g} = {SRC_CVBS, SRC_C, SRC_Y};
        cp = m3[4] ? SRC_C : SRC_CVBS;
        chk({o_dac_a_src, o_dac_b_src, o_dac_c_src, o_dac_d_src},
            m3[3] ? {g, b, c, cp} : {cp, b, c, g});
        if (!m3[5]) chk({o_ttx_bit, o_ttx_request}, 2'h0);
        else chk(o_ttx_request, m3[6] ? i_ttx_bit_slot : 1'b1);
        chk({o_pedestal_on, o_sleep}, {m4[4] & !p[0], m4[6]});
        chk({o_master, o_timing_mode, o_blank_honoured}, {t0[0], t0[2:1], !t0[0] & t0[3]});
        chk(o_vsync_half_lines, m4[3] ? (p[0] ? 3'h5 : 3'h6) : 3'h0);
        chk({o_hsync_width, o_hsync_vsync_offset, o_hsync_pixel_adjust},
            {t1[1:0], t1[3:2], t1[7:6]});
        chk({o_field_edge_offset, o_vsync_width},
            {t0[2:1] == 1 ? t1[5:4] : 2'h0, t0[2:1] == 2 ? t1[5:4] : 2'h0});
        px = pq[1 + t0[5:4] * 15]; // Luma step of 15 clocks
        if (!t0[6]) px[15:8] = 8'h00;
        chk(o_pixel, px);
        chk(o_force_black, m3[7] && px == 16'h0000);
    endtask

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        {i_rst_n, i_pal_mode, i_pixel, i_ttx_pin, i_ttx_bit_slot} = '0;
        {i_scl, sda_drv} = 2'b11;
        seed = 32'hD8139ACE;
        mreset();
        repeat (16) @(negedge i_clk);
        i_rst_n = 1'b1;
        repeat (8) @(negedge i_clk);
        chk_outs();
        for (int a = 1; a <= 8; a++) rdchk(a);
        $display("reset values test done");
        // All sixteen DAC arrangements with random other fields
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            i_pal_mode = seed[8];
            wr(1, 4, {seed[31:24], 1'b0, seed[14:8], seed[7:5], i[3], i[0], seed[2:0],
                {1'b0, seed[22:18], i[1], i[2]}});
            wr(7, 2, {1'b0, seed[30:24], seed[23:16], 16'h0});
            chk_outs();
            rdchk(3);
        end
        for (int a = 1; a <= 7; a += 2) rdchk(a, 2);
        $display("dac matrix and field test done");
        // Counter reset only on the falling half of the toggle
        pulses = 0;
        wr(7, 1, 32'h80000000);
        chk(16'(pulses), 16'h0000);
        wr(7, 1, 32'h0);
        chk(16'(pulses), 16'h0001);
        $display("timing reset test done");
        // Sleep keeps the bus alive; reset wakes
        wr(4, 1, 32'h40000000);
        chk_outs();
        wr(2, 1, 32'h08000000);
        rdchk(2);
        i_rst_n = 1'b0;
        repeat (6) @(negedge i_clk);
        i_rst_n = 1'b1;
        mreset();
        repeat (8) @(negedge i_clk);
        chk_outs();
        $display("sleep test done");
        end_of_test();
    end
endmodule
